/* logic/srap_defs.svh */
// constants of the activate and read path
`ifndef SRAP_DEFS_SVH
`define SRAP_DEFS_SVH
`define SRAP_CLK_NS 40
`define SRAP_ROW_TO_COLUMN_DELAY_NS 20
`define SRAP_RCD_CYC ((`SRAP_ROW_TO_COLUMN_DELAY_NS+`SRAP_CLK_NS-1)/`SRAP_CLK_NS)
`define SRAP_BANK_TO_BANK_ACTIVATE_DELAY_NS 15
`define SRAP_RRD_CYC ((`SRAP_BANK_TO_BANK_ACTIVATE_DELAY_NS+`SRAP_CLK_NS-1)/`SRAP_CLK_NS)
`define SRAP_AP_BIT 10
`define SRAP_CMD_ACT 4'h3
`define SRAP_CMD_READ 4'h5
`define SRAP_CMD_WRITE 4'h4
`define SRAP_CMD_BST 4'h6
`define SRAP_CMD_PRE 4'h2
`define SRAP_BL_FULL 3'h7
`define SRAP_LAT2 2'h2
`define SRAP_LAT3 2'h3
`endif

/* logic/srap_pkg.sv */
// types of the activate and read path
package srap_pkg;
  typedef enum logic [1:0] {
    SRAP_ST_IDLE = 2'b01,
    SRAP_ST_BURST = 2'b10
  } srap_state_t;
endpackage

/* logic/srap_top.sv */
// activate and read path of a four-bank synchronous dram, with its read fifo
`timescale 1ns/1ns
`default_nettype none
`include "srap_defs.svh"

module srap_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module srap_top #(
  parameter int DW = 16,
  parameter int COLW = 4,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // command pins
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [1:0] BA,
  input wire logic [12:0] ADDR,
  input wire logic DQM,
  // data pins
  input wire logic [DW-1:0] DQ_I,
  output logic [DW-1:0] DQ_O,
  output logic DQ_OE,
  // configuration
  input wire logic [1:0] READ_LATENCY_SETTING,
  input wire logic [2:0] BURST_LEN,
  // array load port
  input wire logic LOAD_EN,
  input wire logic [COLW+1:0] LOAD_ADDR,
  input wire logic [DW-1:0] LOAD_DATA,
  // status
  output logic [3:0] BANK_OPEN,
  output logic CMD_ERR,
  output logic WR_INVALID,
  output logic WR_VALID,
  output logic [DW-1:0] WR_DATA
);
  localparam int PW = 4 + 2 + 13 + 1 + DW;
  logic [PW-1:0] s1_r;
  logic [PW-1:0] s2_r;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic [12:0] addr;
  logic dqm_s;
  logic [DW-1:0] dq_s;
  logic act, rd, wr, bst, pre;
  logic [3:0] open_r;
  logic [1:0] rcd_r [4];
  logic [1:0] rrd_r;
  logic [DW-1:0] mem_r [4*(2**COLW)];
  srap_pkg::srap_state_t st_r;
  logic [1:0] bank_r;
  logic [COLW-1:0] col_r;
  logic [8:0] left_r;
  logic ap_r;
  logic full_r;
  logic [8:0] len;
  logic brk, last, push_req, push, ap_now;
  logic [1:0] cur_bank;
  logic [COLW-1:0] cur_col;
  logic f_ready, f_valid, pop;
  logic [DW-1:0] f_data;
  logic [1:0] due_r;
  logic dqm_d1_r;
  logic pend;

  // two flip-flops on every command, mask and data pin
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DQM, DQ_I};
      s2_r <= s1_r;
    end
  end
  assign {cmd, bank, addr, dqm_s, dq_s} = s2_r;

  assign act = (cmd == `SRAP_CMD_ACT);
  assign rd = (cmd == `SRAP_CMD_READ);
  assign wr = (cmd == `SRAP_CMD_WRITE);
  assign bst = (cmd == `SRAP_CMD_BST);
  assign pre = (cmd == `SRAP_CMD_PRE);

  assign ap_now = rd ? addr[`SRAP_AP_BIT] : ap_r;
  assign cur_bank = rd ? bank : bank_r;
  assign cur_col = rd ? addr[COLW-1:0] : col_r;
  assign len = 9'h001 << BURST_LEN[1:0];

  // terminate, precharge of the burst's bank or of all banks, or write stop the burst
  assign brk = bst || wr || (pre && (addr[`SRAP_AP_BIT] || bank == bank_r));
  assign push_req = rd || (st_r == srap_pkg::SRAP_ST_BURST && !brk);
  assign last = rd ? (len == 9'h001 && BURST_LEN != `SRAP_BL_FULL)
                   : (left_r == 9'h001 && !full_r);
  assign push = push_req && f_ready;

  // explicit and auto precharge close alike
  // bank open state, auto precharge closes at last element
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      open_r <= '0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (act && bank == 2'(b)) begin
          open_r[b] <= 1'b1;
        end else if (pre && (addr[`SRAP_AP_BIT] || bank == 2'(b))) begin
          open_r[b] <= 1'b0;
        end else if (push && last && ap_now && cur_bank == 2'(b)) begin
          open_r[b] <= 1'b0;
        end
      end
    end
  end
  assign BANK_OPEN = open_r;

  // row to column count per bank
  generate
    for (genvar g = 0; g < 4; g++) begin : g_rcd
      always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
          rcd_r[g] <= '0;
        end else if (act && bank == 2'(g)) begin
          rcd_r[g] <= 2'(`SRAP_RCD_CYC);
        end else if (rcd_r[g] != '0) begin
          rcd_r[g] <= rcd_r[g] - 1'b1;
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rrd_r <= '0;
    end else if (act) begin
      rrd_r <= 2'(`SRAP_RRD_CYC) - 1'b1;
    end else if (rrd_r != '0) begin
      rrd_r <= rrd_r - 1'b1;
    end
  end

  // misuse of bank state is flagged
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CMD_ERR <= 1'b0;
    end else begin
      CMD_ERR <= (act && (open_r[bank] || rrd_r != '0))
              || ((rd || wr) && (!open_r[bank] || rcd_r[bank] > 2'h1));
    end
  end

  // array storage
  always_ff @(posedge CORE_CLK) begin
    if (LOAD_EN) begin
      mem_r[LOAD_ADDR] <= LOAD_DATA;
    end
  end

  // a new read restarts the engine at once
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= srap_pkg::SRAP_ST_IDLE;
      bank_r <= '0;
      col_r <= '0;
      left_r <= '0;
      ap_r <= 1'b0;
      full_r <= 1'b0;
    end else begin
      if (rd) begin
        bank_r <= bank;
        ap_r <= addr[`SRAP_AP_BIT];
        full_r <= (BURST_LEN == `SRAP_BL_FULL);
        left_r <= len - 9'h001;
        col_r <= addr[COLW-1:0] + 1'b1;
      end else if (push) begin
        left_r <= left_r - 9'h001;
        col_r <= col_r + 1'b1;
      end
      unique case (st_r)
        srap_pkg::SRAP_ST_IDLE: begin
          if (rd && !last) begin
            st_r <= srap_pkg::SRAP_ST_BURST;
          end
        end
        srap_pkg::SRAP_ST_BURST: begin
          if (rd) begin
            st_r <= last ? srap_pkg::SRAP_ST_IDLE : srap_pkg::SRAP_ST_BURST;
          end else if (brk || (push && last)) begin
            st_r <= srap_pkg::SRAP_ST_IDLE;
          end
        end
        default: begin
          st_r <= srap_pkg::SRAP_ST_IDLE;
        end
      endcase
    end
  end

  // element fifo
  srap_fifo #(.W(DW), .D(DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .flush(wr),
    .in_valid(push_req),
    .in_ready(f_ready),
    .in_data(mem_r[{cur_bank, cur_col}]),
    .out_valid(f_valid),
    .out_ready(pop),
    .out_data(f_data)
  );

  // due markers time each element by the latency
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      due_r <= '0;
    end else if (wr) begin
      due_r <= '0;
    end else begin
      due_r <= {due_r[0], push};
    end
  end
  assign pop = f_valid && !wr
            && (READ_LATENCY_SETTING == `SRAP_LAT3 ? due_r[1] : due_r[0]);

  // mask from two clocks before gates the buffers
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      dqm_d1_r <= 1'b0;
    end else begin
      dqm_d1_r <= dqm_s;
    end
  end

  // drive only for a due element, back to back
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DQ_O <= '0;
      DQ_OE <= 1'b0;
    end else begin
      if (pop) begin
        DQ_O <= f_data;
      end
      DQ_OE <= pop && !dqm_d1_r;
    end
  end

  // write over pending read without mask is invalid
  assign pend = f_valid || (due_r != '0) || DQ_OE;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WR_INVALID <= 1'b0;
    end else begin
      WR_INVALID <= wr && pend && !dqm_d1_r;
    end
  end

  // write data mask with no latency
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      WR_VALID <= 1'b0;
      WR_DATA <= '0;
    end else begin
      WR_VALID <= wr && !dqm_s;
      if (wr && !dqm_s) begin
        WR_DATA <= dq_s;
      end
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  a_act_opens: assert property (act |=> BANK_OPEN[$past(bank)])
    else $error("activate did not open bank");
  a_rd_closed: assert property (rd && !open_r[bank] |=> CMD_ERR)
    else $error("read to closed bank not flagged");
  a_act_twice: assert property (act && open_r[bank] |=> CMD_ERR)
    else $error("activate to open bank not flagged");
  a_other_bank: assert property (act && !open_r[bank] && rrd_r == '0 |=> !CMD_ERR)
    else $error("legal activate refused");
  a_ap_close: assert property (push && last && ap_now && !act
    |=> !BANK_OPEN[$past(cur_bank)])
    else $error("auto precharge left row open");
  a_lat_two: assert property (push && !wr && READ_LATENCY_SETTING == `SRAP_LAT2
    && f_valid == 1'b0 ##1 !wr |-> f_valid && pop)
    else $error("element not due after latency");
  a_release: assert property (!pop |=> !DQ_OE)
    else $error("data lines driven without element");
  a_mask_two: assert property (dqm_s ##1 pop |=> !DQ_OE)
    else $error("mask latency wrong");
  a_wr_hiz: assert property (wr |=> !DQ_OE ##1 !DQ_OE)
    else $error("lines driven after write");
  a_wr_inval: assert property (wr && DQ_OE && !$past(dqm_s) |=> WR_INVALID)
    else $error("unmasked write over read not flagged");
  a_wr_mask: assert property (wr && dqm_s |=> !WR_VALID)
    else $error("masked write data taken");
  a_bst_stop: assert property (bst && !rd |=> st_r == srap_pkg::SRAP_ST_IDLE)
    else $error("terminate did not end burst");
  a_seamless: assert property (rd |-> f_ready && push)
    else $error("read refused");

  c_two_reads: cover property (rd ##1 rd);
  c_rd_wr: cover property (rd ##[1:4] dqm_s ##2 wr);
  c_ap_read: cover property (rd && addr[`SRAP_AP_BIT] ##[1:12] !open_r[bank_r]);
endmodule
`default_nettype wire

/* tb/srap_ctl_model.sv */
// far-side controller model driving command, mask and data pins
`timescale 1ns/1ns
`default_nettype none
`include "srap_defs.svh"
module srap_ctl_model (
  // clock
  input wire logic clk,
  // command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [1:0] ba,
  output logic [12:0] addr,
  output logic dqm,
  // data pins
  output logic [15:0] dq
);
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 13'h0000;
    dqm = 1'b0;
    dq = 16'h0000;
  end
  // one command per edge, write data with its command
  task cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic m,
           input logic [15:0] d);
    @(negedge clk);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba = b;
    addr = a;
    dqm = m;
    dq = (c == `SRAP_CMD_WRITE) ? d : ~dq;
  endtask
  task nop(input int n, input logic m);
    repeat (n) cmd(4'h7, ~ba, ~addr, m, 16'h0000);
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench of the activate and read path
`timescale 1ns/1ns
`default_nettype none
`include "srap_defs.svh"
module tb;
  logic clk, rst, cs_n, ras_n, cas_n, we_n, dqm, load_en, dq_oe, cmd_err, wr_inv, wr_val;
  logic [1:0] ba, lat_s;
  logic [12:0] addr;
  logic [15:0] dq_i, dq_o, wr_data, load_data;
  logic [2:0] bl;
  logic [5:0] load_addr;
  logic [3:0] bank_open;
  logic [1:0] ev [0:4095];
  logic [2:0] ep [0:4095];
  logic [15:0] ed [0:4095];
  logic [15:0] ew [0:4095];
  logic [15:0] mem [0:63];
  int cyc, lat, fail_count, n_compared, seed, k, i, j, n;

  srap_ctl_model m (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dqm(dqm), .dq(dq_i));
  srap_top #(.DW(16), .COLW(4), .DEPTH(8)) dut (.CORE_CLK(clk), .RST(rst), .CS_N(cs_n),
    .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .DQM(dqm), .DQ_I(dq_i),
    .DQ_O(dq_o), .DQ_OE(dq_oe), .READ_LATENCY_SETTING(lat_s), .BURST_LEN(bl),
    .LOAD_EN(load_en), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data), .BANK_OPEN(bank_open),
    .CMD_ERR(cmd_err), .WR_INVALID(wr_inv), .WR_VALID(wr_val), .WR_DATA(wr_data));

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function int blen(input logic [2:0] c);
    return (c == 3'h7) ? 64 : (1 << c);
  endfunction
  task fill(input int s, input logic [1:0] v);
    for (j = s; j < s + 64; j++) ev[j] = v;
  endtask
  task rd(input logic [1:0] bk, input logic [3:0] col, input logic ap, input logic bad);
    m.cmd(`SRAP_CMD_READ, bk, {2'h0, ap, 6'h00, col}, 1'b0, 16'h0000);
    k = cyc;
    fill(k + 2 + lat, bad ? 2'h2 : 2'h0);
    if (bad) ep[k + 3] = 3'h4;
    else for (i = 0; i < blen(bl); i++) begin
      ev[k + 2 + lat + i] = 2'h1;
      ed[k + 2 + lat + i] = mem[{bk, col + 4'(i)}];
    end
  endtask
  task stop(input logic [3:0] c, input logic [1:0] bk);
    m.cmd(c, bk, 13'h0000, 1'b0, 16'h0000);
    k = cyc;
    fill(k + 2 + lat, 2'h0);
  endtask
  task act(input logic [1:0] bk, input logic err);
    m.cmd(`SRAP_CMD_ACT, bk, 13'($random(seed)), 1'b0, 16'h0000);
    k = cyc;
    ep[k + 3] = {err, 2'h0};
  endtask
  task wr(input logic [1:0] bk, input logic mq, input logic [2:0] pe, input logic [1:0] fv);
    logic [15:0] d;
    d = 16'($random(seed));
    m.cmd(`SRAP_CMD_WRITE, bk, 13'h0000, mq, d);
    k = cyc;
    ep[k + 3] = pe;
    ew[k + 3] = d;
    fill(k + 2, 2'h0);
    ev[k + 2] = fv;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done;
    end
  end
  always @(negedge clk) begin
    if (ev[cyc] != 2'h2) check("dq_oe", dq_oe, ev[cyc][0]);
    if (ev[cyc] == 2'h1) check("dq_o", dq_o, ed[cyc]);
    check("pulses", {cmd_err, wr_inv, wr_val}, ep[cyc]);
    if (ep[cyc][0]) check("wr_data", wr_data, ew[cyc]);
  end

  initial begin
    seed = 32'ha5b5286d;
    rst = 1'b1;
    lat = 2;
    lat_s = 2'h2;
    bl = 3'h1;
    load_en = 1'b0;
    load_addr = 6'h00;
    load_data = 16'h0000;
    fail_count = 0;
    n_compared = 0;
    cyc = 0;
    for (i = 0; i < 4096; i++) begin
      ev[i] = 2'h0;
      ep[i] = 3'h0;
    end
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check("bank_open", bank_open, 4'h0);
    for (i = 0; i < 64; i++) begin
      @(negedge clk);
      load_en = 1'b1;
      load_addr = 6'(i);
      load_data = 16'($random(seed));
      mem[i] = load_data;
    end
    @(negedge clk);
    load_en = 1'b0;
    for (n = 0; n < 4; n++) act(2'(n), 1'b0);
    m.nop(4, 1'b0);
    check("bank_open", bank_open, 4'hf);
    act(2'h0, 1'b1);
    m.nop(4, 1'b0);
    for (n = 0; n < 8; n++) begin
      lat = 2 + n[2];
      lat_s = 2'(lat);
      bl = 3'(n[1:0]);
      rd(2'($random(seed)), 4'($random(seed)), 1'b0, 1'b0);
      m.nop(12, 1'b0);
    end
    bl = 3'h1;
    for (n = 0; n < 6; n++) rd(2'($random(seed)), 4'($random(seed)), 1'b0, 1'b0);
    for (n = 0; n < 3; n++) begin
      rd(2'($random(seed)), 4'($random(seed)), 1'b0, 1'b0);
      m.nop(1, 1'b0);
    end
    m.nop(10, 1'b0);
    bl = 3'h3;
    rd(2'h1, 4'hd, 1'b0, 1'b0);
    m.nop(2, 1'b0);
    stop(`SRAP_CMD_BST, 2'h1);
    m.nop(10, 1'b0);
    bl = 3'h7;
    rd(2'h2, 4'h9, 1'b0, 1'b0);
    m.nop(20, 1'b0);
    stop(`SRAP_CMD_BST, 2'h2);
    m.nop(12, 1'b0);
    bl = 3'h2;
    rd(2'h3, 4'h2, 1'b0, 1'b0);
    m.nop(3, 1'b0);
    stop(`SRAP_CMD_PRE, 2'h3);
    m.nop(10, 1'b0);
    check("bank_open", bank_open, 4'h7);
    rd(2'h3, 4'h0, 1'b0, 1'b1);
    m.nop(12, 1'b0);
    act(2'h3, 1'b0);
    m.nop(2, 1'b0);
    rd(2'h3, 4'h5, 1'b1, 1'b0);
    m.nop(10, 1'b0);
    check("bank_open", bank_open, 4'h7);
    act(2'h3, 1'b0);
    m.nop(2, 1'b0);
    rd(2'h3, 4'h6, 1'b0, 1'b0);
    m.nop(10, 1'b0);
    check("bank_open", bank_open, 4'hf);
    bl = 3'h3;
    rd(2'h0, 4'h1, 1'b0, 1'b0);
    m.nop(1, 1'b0);
    m.nop(2, 1'b1);
    wr(2'h0, 1'b0, 3'h1, 2'h0);
    m.nop(12, 1'b0);
    rd(2'h0, 4'h3, 1'b0, 1'b0);
    m.nop(3, 1'b0);
    wr(2'h0, 1'b1, 3'h2, 2'h2);
    m.nop(12, 1'b0);
    bl = 3'h0;
    rd(2'h1, 4'h4, 1'b0, 1'b0);
    m.nop(lat, 1'b0);
    wr(2'h1, 1'b0, 3'h1, 2'h0);
    m.nop(12, 1'b0);
    // precharge of every bank at once
    m.cmd(`SRAP_CMD_PRE, 2'h0, 13'h0400, 1'b0, 16'h0000);
    m.nop(4, 1'b0);
    check("bank_open", bank_open, 4'h0);
    test_done;
  end
endmodule
`default_nettype wire
